// ==== verilog/dbu_core.sv ====
// debug breakpoint unit: snapshots, cause record, stop vector,
// scratch words and hardware break and watch points
// assumes core trace inputs synchronous to CLOCK, apb master on the bus
`timescale 1ns/1ns
// What this block does
// - capture saved status word on debug entry
// - status layout, bit 8 read-only, bit 5 reserved
// - capture saved program counter on entry
// - capture saved stack pointer on entry
// - register fetch thread select, 8 bits
// - register fetch register select, 5 bits
// - record entry cause code, reset zero
// - record trigger index, zero for host/call
// - simultaneous triggers of one kind report lowest index
// - record causing thread, zero for host
// - load address or resource id on watch
// - stop vector holds threads after return
// - eight scratch words shared with config space
// - four instruction breakpoints on pc match
// - condition bit selects equal or differ
// - per-thread mask gates instruction breakpoints
// - enable bit gates each instruction breakpoint
// - four data watchpoints with two addresses
// - load enable, and/or, enable, thread mask
// - four resource watchpoints, mask and value
module dbu_core
   import dbu_pkg::*;
#(
   parameter int NUM_BP = 4,
   parameter int NUM_SCR = 8
) (
   // clock and reset
   input wire logic CLOCK,
   input wire logic RSTN,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // entry requests and interrupted thread state
   input wire logic HOST_REQ,
   input wire logic CALL_REQ,
   input wire logic [7:0] CALL_THREAD,
   input wire logic DEBUG_RETURN,
   input wire logic [31:0] CUR_STATUS,
   input wire logic [31:0] CUR_PC,
   input wire logic [31:0] CUR_SP,
   // instruction, memory and resource trace
   input wire logic PC_VALID,
   input wire logic [31:0] PC,
   input wire logic [7:0] PC_THREAD,
   input wire logic MEM_VALID,
   input wire logic MEM_LOAD,
   input wire logic [31:0] MEM_ADDR,
   input wire logic [7:0] MEM_THREAD,
   input wire logic RES_VALID,
   input wire logic [31:0] RES_ID,
   input wire logic [7:0] RES_THREAD,
   // tile configuration access to scratch words
   input wire logic CFG_WE,
   input wire logic [2:0] CFG_IDX,
   input wire logic [31:0] CFG_WDATA,
   output logic [31:0] CFG_RDATA,
   // core control
   output logic DEBUG_ENTRY,
   output logic IN_DEBUG,
   output logic [7:0] THREAD_STOP,
   output logic [7:0] FETCH_THREAD,
   output logic [4:0] FETCH_REG
);

   // thread mask test, thread numbers above 7 never match
   function automatic logic thr_ok(input logic [31:0] ctl, input logic [7:0] thr);
      thr_ok = (thr < 8'h08) && ctl[CTL_TMASK_LSB + int'(thr[2:0])];
   endfunction

   // lowest set bit of a trigger vector
   function automatic logic [1:0] lowest(input logic [3:0] v);
      lowest = v[0] ? 2'h0 : v[1] ? 2'h1 : v[2] ? 2'h2 : 2'h3;
   endfunction

   logic [31:0] status_r, status_nxt, pc_snap_r, pc_snap_nxt, sp_snap_r, sp_snap_nxt;
   logic [31:0] fthr_r, fthr_nxt, freg_r, freg_nxt;
   logic [31:0] cause_r, cause_nxt, data_r, data_nxt, stop_r, stop_nxt;
   logic [31:0] scr_r [NUM_SCR], scr_nxt [NUM_SCR];
   logic [31:0] ibaddr_r [NUM_BP];
   logic [31:0] ibaddr_nxt [NUM_BP];
   logic [31:0] ibctl_r [NUM_BP];
   logic [31:0] ibctl_nxt [NUM_BP];
   logic [31:0] dwa1_r [NUM_BP];
   logic [31:0] dwa1_nxt [NUM_BP];
   logic [31:0] dwa2_r [NUM_BP];
   logic [31:0] dwa2_nxt [NUM_BP];
   logic [31:0] dwctl_r [NUM_BP];
   logic [31:0] dwctl_nxt [NUM_BP];
   logic [31:0] rwmask_r [NUM_BP];
   logic [31:0] rwmask_nxt [NUM_BP];
   logic [31:0] rwval_r [NUM_BP];
   logic [31:0] rwval_nxt [NUM_BP];
   logic [31:0] rwctl_r [NUM_BP];
   logic [31:0] rwctl_nxt [NUM_BP];
   logic in_dbg_r, in_dbg_nxt, entry_r, entry_nxt;
   logic [31:0] cfg_rd_r, cfg_rd_nxt;
   dbu_apb_t apb_r, apb_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;

   logic [3:0] ib_hit, dw_hit, rw_hit;
   logic take;
   logic [2:0] ent_cause;
   logic [1:0] ent_idx;
   logic [7:0] ent_thr;
   logic [9:0] idx;
   logic wr_en;

   assign idx = PADDR[11:2];
   assign wr_en = PSEL && PENABLE && PWRITE && (apb_r == DBU_ACCESS) && PADDR[1:0] == 2'h0;

   // trigger detection
   always_comb begin
      logic ca, cb;
      ca = 1'b0;
      cb = 1'b0;
      for (int i = 0; i < NUM_BP; i++) begin
         ib_hit[i] = PC_VALID && ibctl_r[i][CTL_EN] && thr_ok(ibctl_r[i], PC_THREAD) &&
            (ibctl_r[i][CTL_COND] ? (PC != ibaddr_r[i]) : (PC == ibaddr_r[i]));
         ca = MEM_ADDR >= dwa1_r[i];
         cb = MEM_ADDR <= dwa2_r[i];
         dw_hit[i] = MEM_VALID && dwctl_r[i][CTL_EN] && thr_ok(dwctl_r[i], MEM_THREAD) &&
            (!MEM_LOAD || dwctl_r[i][CTL_LOAD]) &&
            (dwctl_r[i][CTL_COND] ? (ca || cb) : (ca && cb));
         ca = (RES_ID & rwmask_r[i]) == rwval_r[i];
         rw_hit[i] = RES_VALID && rwctl_r[i][CTL_EN] && thr_ok(rwctl_r[i], RES_THREAD) &&
            (rwctl_r[i][CTL_COND] ? !ca : ca);
      end
   end

   // entry arbitration: host, call, instruction, data, resource
   always_comb begin
      take = !in_dbg_r;
      ent_cause = CAUSE_NONE;
      ent_idx = 2'h0;
      ent_thr = 8'h00;
      if (HOST_REQ) begin
         ent_cause = CAUSE_HOST;
      end else if (CALL_REQ) begin
         ent_cause = CAUSE_CALL;
         ent_thr = CALL_THREAD;
      end else if (|ib_hit) begin
         ent_cause = CAUSE_IBREAK;
         ent_idx = lowest(ib_hit);
         ent_thr = PC_THREAD;
      end else if (|dw_hit) begin
         ent_cause = CAUSE_DWATCH;
         ent_idx = lowest(dw_hit);
         ent_thr = MEM_THREAD;
      end else if (|rw_hit) begin
         ent_cause = CAUSE_RWATCH;
         ent_idx = lowest(rw_hit);
         ent_thr = RES_THREAD;
      end else begin
         take = 1'b0;
      end
   end

   // register file next state, entry capture wins over a bus write
   always_comb begin
      status_nxt = status_r;
      pc_snap_nxt = pc_snap_r;
      sp_snap_nxt = sp_snap_r;
      fthr_nxt = fthr_r;
      freg_nxt = freg_r;
      cause_nxt = cause_r;
      data_nxt = data_r;
      stop_nxt = stop_r;
      scr_nxt = scr_r;
      ibaddr_nxt = ibaddr_r;
      ibctl_nxt = ibctl_r;
      dwa1_nxt = dwa1_r;
      dwa2_nxt = dwa2_r;
      dwctl_nxt = dwctl_r;
      rwmask_nxt = rwmask_r;
      rwval_nxt = rwval_r;
      rwctl_nxt = rwctl_r;
      in_dbg_nxt = in_dbg_r;
      entry_nxt = take;
      if (wr_en) begin
         case (idx)
            IDX_SAVED_STATUS: status_nxt = (status_r & ~STATUS_WMASK) | (PWDATA & STATUS_WMASK);
            IDX_SAVED_PC: pc_snap_nxt = PWDATA;
            IDX_SAVED_SP: sp_snap_nxt = PWDATA;
            IDX_FTHR: fthr_nxt = PWDATA & FTHR_WMASK;
            IDX_FREG: freg_nxt = PWDATA & FREG_WMASK;
            IDX_CAUSE: cause_nxt = PWDATA & CAUSE_WMASK;
            IDX_DATA: data_nxt = PWDATA;
            IDX_STOP: stop_nxt = PWDATA & STOP_WMASK;
            default: begin
               for (int i = 0; i < NUM_SCR; i++) begin
                  if (idx == IDX_SCR + 10'(i)) scr_nxt[i] = PWDATA;
               end
               for (int i = 0; i < NUM_BP; i++) begin
                  if (idx == IDX_IBADDR + 10'(i)) ibaddr_nxt[i] = PWDATA;
                  if (idx == IDX_IBCTL + 10'(i)) ibctl_nxt[i] = PWDATA & IBCTL_WMASK;
                  if (idx == IDX_DWADDR1 + 10'(i)) dwa1_nxt[i] = PWDATA;
                  if (idx == IDX_DWADDR2 + 10'(i)) dwa2_nxt[i] = PWDATA;
                  if (idx == IDX_DWCTL + 10'(i)) dwctl_nxt[i] = PWDATA & DWCTL_WMASK;
                  if (idx == IDX_RWMASK + 10'(i)) rwmask_nxt[i] = PWDATA;
                  if (idx == IDX_RWVAL + 10'(i)) rwval_nxt[i] = PWDATA;
                  if (idx == IDX_RWCTL + 10'(i)) rwctl_nxt[i] = PWDATA & RWCTL_WMASK;
               end
            end
         endcase
      end
      if (CFG_WE) scr_nxt[CFG_IDX] = CFG_WDATA;
      if (DEBUG_RETURN) in_dbg_nxt = 1'b0;
      if (take) begin
         in_dbg_nxt = 1'b1;
         status_nxt = CUR_STATUS & STATUS_CAPMASK;
         pc_snap_nxt = CUR_PC;
         sp_snap_nxt = CUR_SP;
         cause_nxt = {14'h0000, ent_idx, ent_thr, 5'h00, ent_cause};
         if (ent_cause == CAUSE_DWATCH) data_nxt = MEM_ADDR;
         if (ent_cause == CAUSE_RWATCH) data_nxt = RES_ID;
      end
   end

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         status_r <= REG_RESET;
         pc_snap_r <= REG_RESET;
         sp_snap_r <= REG_RESET;
         fthr_r <= REG_RESET;
         freg_r <= REG_RESET;
         cause_r <= REG_RESET;
         data_r <= REG_RESET;
         stop_r <= REG_RESET;
         for (int i = 0; i < NUM_SCR; i++) scr_r[i] <= REG_RESET;
         for (int i = 0; i < NUM_BP; i++) begin
            ibaddr_r[i] <= REG_RESET;
            ibctl_r[i] <= REG_RESET;
            dwa1_r[i] <= REG_RESET;
            dwa2_r[i] <= REG_RESET;
            dwctl_r[i] <= REG_RESET;
            rwmask_r[i] <= REG_RESET;
            rwval_r[i] <= REG_RESET;
            rwctl_r[i] <= REG_RESET;
         end
         in_dbg_r <= 1'b0;
         entry_r <= 1'b0;
      end else begin
         status_r <= status_nxt;
         pc_snap_r <= pc_snap_nxt;
         sp_snap_r <= sp_snap_nxt;
         fthr_r <= fthr_nxt;
         freg_r <= freg_nxt;
         cause_r <= cause_nxt;
         data_r <= data_nxt;
         stop_r <= stop_nxt;
         scr_r <= scr_nxt;
         ibaddr_r <= ibaddr_nxt;
         ibctl_r <= ibctl_nxt;
         dwa1_r <= dwa1_nxt;
         dwa2_r <= dwa2_nxt;
         dwctl_r <= dwctl_nxt;
         rwmask_r <= rwmask_nxt;
         rwval_r <= rwval_nxt;
         rwctl_r <= rwctl_nxt;
         in_dbg_r <= in_dbg_nxt;
         entry_r <= entry_nxt;
      end
   end

   // apb slave: answer in the first access cycle
   always_comb begin
      apb_nxt = apb_r;
      prdata_nxt = prdata_r;
      pready_nxt = 1'b0;
      pslverr_nxt = 1'b0;
      cfg_rd_nxt = scr_nxt[CFG_IDX];
      case (apb_r)
         DBU_IDLE, DBU_ACCESS: begin
            apb_nxt = DBU_IDLE;
            if (PSEL && !PENABLE) begin
               apb_nxt = DBU_ACCESS;
               pready_nxt = 1'b1;
               pslverr_nxt = 1'b1;
               prdata_nxt = 32'h0000_0000;
               case (idx)
                  IDX_SAVED_STATUS: prdata_nxt = status_r;
                  IDX_SAVED_PC: prdata_nxt = pc_snap_r;
                  IDX_SAVED_SP: prdata_nxt = sp_snap_r;
                  IDX_FTHR: prdata_nxt = fthr_r;
                  IDX_FREG: prdata_nxt = freg_r;
                  IDX_CAUSE: prdata_nxt = cause_r;
                  IDX_DATA: prdata_nxt = data_r;
                  IDX_STOP: prdata_nxt = stop_r;
                  default: prdata_nxt = 32'h0000_0000;
               endcase
               if (idx <= IDX_DATA && idx >= IDX_SAVED_STATUS || idx == IDX_STOP) pslverr_nxt = 1'b0;
               for (int i = 0; i < NUM_SCR; i++) begin
                  if (idx == IDX_SCR + 10'(i)) begin
                     prdata_nxt = scr_r[i];
                     pslverr_nxt = 1'b0;
                  end
               end
               for (int i = 0; i < NUM_BP; i++) begin
                  if (idx == IDX_IBADDR + 10'(i)) prdata_nxt = ibaddr_r[i];
                  if (idx == IDX_IBCTL + 10'(i)) prdata_nxt = ibctl_r[i];
                  if (idx == IDX_DWADDR1 + 10'(i)) prdata_nxt = dwa1_r[i];
                  if (idx == IDX_DWADDR2 + 10'(i)) prdata_nxt = dwa2_r[i];
                  if (idx == IDX_DWCTL + 10'(i)) prdata_nxt = dwctl_r[i];
                  if (idx == IDX_RWMASK + 10'(i)) prdata_nxt = rwmask_r[i];
                  if (idx == IDX_RWVAL + 10'(i)) prdata_nxt = rwval_r[i];
                  if (idx == IDX_RWCTL + 10'(i)) prdata_nxt = rwctl_r[i];
                  if (idx == IDX_IBADDR + 10'(i) || idx == IDX_IBCTL + 10'(i) ||
                      idx == IDX_DWADDR1 + 10'(i) || idx == IDX_DWADDR2 + 10'(i) ||
                      idx == IDX_DWCTL + 10'(i) || idx == IDX_RWMASK + 10'(i) ||
                      idx == IDX_RWVAL + 10'(i) || idx == IDX_RWCTL + 10'(i))
                     pslverr_nxt = 1'b0;
               end
               if (PADDR[1:0] != 2'h0) pslverr_nxt = 1'b1;
               if (PWRITE) prdata_nxt = 32'h0000_0000;
            end
         end
         default: apb_nxt = DBU_IDLE;
      endcase
   end

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         apb_r <= DBU_IDLE;
         prdata_r <= REG_RESET;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         cfg_rd_r <= REG_RESET;
      end else begin
         apb_r <= apb_nxt;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         cfg_rd_r <= cfg_rd_nxt;
      end
   end

   assign PRDATA = prdata_r;
   assign PREADY = pready_r;
   assign PSLVERR = pslverr_r;
   assign CFG_RDATA = cfg_rd_r;
   assign DEBUG_ENTRY = entry_r;
   assign IN_DEBUG = in_dbg_r;
   assign THREAD_STOP = stop_r[7:0];
   assign FETCH_THREAD = fthr_r[7:0];
   assign FETCH_REG = freg_r[4:0];

   // checks
   chk_status_capture: assert property (@(posedge CLOCK) disable iff (!RSTN)
      take |=> status_r == ($past(CUR_STATUS) & STATUS_CAPMASK))
      else $error("status snapshot not captured");
   chk_status_reserved: assert property (@(posedge CLOCK) disable iff (!RSTN)
      status_r[5] == 1'b0 && status_r[31:11] == 21'h0)
      else $error("status reserved bit set");
   chk_status_readonly: assert property (@(posedge CLOCK) disable iff (!RSTN)
      wr_en && idx == IDX_SAVED_STATUS && !take |=> $stable(status_r[8]))
      else $error("status read-only bit changed");
   chk_pc_sp_capture: assert property (@(posedge CLOCK) disable iff (!RSTN)
      take |=> pc_snap_r == $past(CUR_PC) && sp_snap_r == $past(CUR_SP) && DEBUG_ENTRY)
      else $error("pc or sp snapshot wrong");
   chk_host_record: assert property (@(posedge CLOCK) disable iff (!RSTN)
      take && HOST_REQ |=> cause_r == {29'h0, CAUSE_HOST})
      else $error("host entry record wrong");
   chk_lowest_index: assert property (@(posedge CLOCK) disable iff (!RSTN)
      take && !HOST_REQ && !CALL_REQ && |ib_hit |=> cause_r[2:0] == CAUSE_IBREAK &&
      ($past(ib_hit) & ((4'h2 << cause_r[17:16]) - 4'h1)) == (4'h1 << cause_r[17:16]))
      else $error("breakpoint index not lowest");
   chk_ib_gated: assert property (@(posedge CLOCK) disable iff (!RSTN)
      take && ent_cause == CAUSE_IBREAK |-> ibctl_r[ent_idx][CTL_EN] && PC_THREAD < 8'h08)
      else $error("breakpoint fired while disabled");
   chk_watch_data: assert property (@(posedge CLOCK) disable iff (!RSTN)
      take && ent_cause == CAUSE_DWATCH |=> data_r == $past(MEM_ADDR) ##1 IN_DEBUG)
      else $error("watch address not recorded");
   chk_scratch_shared: assert property (@(posedge CLOCK) disable iff (!RSTN)
      CFG_WE |=> CFG_RDATA == $past(CFG_WDATA) || $past(CFG_IDX) != CFG_IDX)
      else $error("scratch write not seen");
   chk_stop_vector: assert property (@(posedge CLOCK) disable iff (!RSTN)
      wr_en && idx == IDX_STOP |=> THREAD_STOP == $past(PWDATA[7:0]))
      else $error("stop vector not written");
   chk_apb_answer: assert property (@(posedge CLOCK) disable iff (!RSTN)
      PSEL && !PENABLE |=> PREADY ##1 !PREADY)
      else $error("apb answer not one cycle");
   cov_host: cover property (@(posedge CLOCK) take && HOST_REQ);
   cov_dual_ib: cover property (@(posedge CLOCK) take && ib_hit[1] && ib_hit[2]);
   cov_rwatch: cover property (@(posedge CLOCK) take && ent_cause == CAUSE_RWATCH);

endmodule

// ==== verilog/dbu_pkg.sv ====
// debug breakpoint unit: register map, field layout and codes
// assumes registers on an apb bus, one word per register index
package dbu_pkg;
   // register indices; byte address is four times the index
   localparam logic [9:0] IDX_SAVED_STATUS = 10'h010;
   localparam logic [9:0] IDX_SAVED_PC = 10'h011;
   localparam logic [9:0] IDX_SAVED_SP = 10'h012;
   localparam logic [9:0] IDX_FTHR = 10'h013;
   localparam logic [9:0] IDX_FREG = 10'h014;
   localparam logic [9:0] IDX_CAUSE = 10'h015;
   localparam logic [9:0] IDX_DATA = 10'h016;
   localparam logic [9:0] IDX_STOP = 10'h018;
   localparam logic [9:0] IDX_SCR = 10'h020;
   localparam logic [9:0] IDX_IBADDR = 10'h030;
   localparam logic [9:0] IDX_IBCTL = 10'h040;
   localparam logic [9:0] IDX_DWADDR1 = 10'h050;
   localparam logic [9:0] IDX_DWADDR2 = 10'h060;
   localparam logic [9:0] IDX_DWCTL = 10'h070;
   localparam logic [9:0] IDX_RWMASK = 10'h080;
   localparam logic [9:0] IDX_RWVAL = 10'h090;
   localparam logic [9:0] IDX_RWCTL = 10'h09C;
   // writable bits of the masked registers, and the captured bits of status
   localparam logic [31:0] STATUS_WMASK = 32'h0000_06DF;
   localparam logic [31:0] STATUS_CAPMASK = 32'h0000_07DF;
   localparam logic [31:0] FTHR_WMASK = 32'h0000_00FF;
   localparam logic [31:0] FREG_WMASK = 32'h0000_001F;
   localparam logic [31:0] CAUSE_WMASK = 32'h0003_FF07;
   localparam logic [31:0] STOP_WMASK = 32'h0000_00FF;
   localparam logic [31:0] IBCTL_WMASK = 32'h00FF_0003;
   localparam logic [31:0] DWCTL_WMASK = 32'h00FF_0007;
   localparam logic [31:0] RWCTL_WMASK = 32'h00FF_0003;
   // field positions
   localparam int CAUSE_LSB = 0;
   localparam int THREAD_LSB = 8;
   localparam int INDEX_LSB = 16;
   localparam int CTL_EN = 0;
   localparam int CTL_COND = 1;
   localparam int CTL_LOAD = 2;
   localparam int CTL_TMASK_LSB = 16;
   // reset value of all state
   localparam logic [31:0] REG_RESET = 32'h0000_0000;
   // debug entry causes
   localparam logic [2:0] CAUSE_NONE = 3'h0;
   localparam logic [2:0] CAUSE_HOST = 3'h1;
   localparam logic [2:0] CAUSE_CALL = 3'h2;
   localparam logic [2:0] CAUSE_IBREAK = 3'h3;
   localparam logic [2:0] CAUSE_DWATCH = 3'h4;
   localparam logic [2:0] CAUSE_RWATCH = 3'h5;
   typedef enum logic [1:0] {DBU_IDLE, DBU_SETUP, DBU_ACCESS} dbu_apb_t;
endpackage

// ==== tb/dbu_core_model.sv ====
// partner: interrupted thread state and debug rom return
// assumes it shares CLOCK and RSTN with the debug unit
`timescale 1ns/1ns
module dbu_core_model
   import dbu_pkg::*;
(
   // clock and reset
   input wire logic CLOCK,
   input wire logic RSTN,
   // bench control
   input wire logic [7:0] THR,
   input wire logic [3:0] RET_DLY,
   // unit side
   input wire logic IN_DEBUG,
   output logic DEBUG_RETURN,
   output logic [31:0] CUR_STATUS,
   output logic [31:0] CUR_PC,
   output logic [31:0] CUR_SP
);
   logic [3:0] cnt_r;
   // state tied to thread so a stale capture shows
   assign CUR_STATUS = ~{24'h0, THR};
   assign CUR_PC = 32'h1000_0000 | {24'h0, THR};
   assign CUR_SP = 32'h2000_0000 | {24'h0, THR};
   // return pulse after a chosen delay
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         cnt_r <= 4'h0;
         DEBUG_RETURN <= 1'b0;
      end else if (IN_DEBUG && !DEBUG_RETURN) begin
         cnt_r <= cnt_r + 4'h1;
         DEBUG_RETURN <= (cnt_r == RET_DLY);
      end else begin
         cnt_r <= 4'h0;
         DEBUG_RETURN <= 1'b0;
      end
   end
endmodule

// ==== tb/testbench.sv ====
// bench: registers, entries, break and watch points, scratch
// assumes the core model partner; apb master driven here
`timescale 1ns/1ns
module testbench
   import dbu_pkg::*;
;
   logic CLOCK = 0, RSTN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, HOST_REQ = 0, CALL_REQ = 0;
   logic PC_VALID = 0, MEM_VALID = 0, MEM_LOAD = 0, RES_VALID = 0, CFG_WE = 0;
   logic [11:0] PADDR = 0;
   logic [31:0] PWDATA = 0, PC = 0, MEM_ADDR = 0, RES_ID = 0, CFG_WDATA = 0;
   logic [7:0] CALL_THREAD = 0, PC_THREAD = 0, MEM_THREAD = 0, RES_THREAD = 0, thr = 0;
   logic [2:0] CFG_IDX = 0;
   logic [3:0] ret_dly = 0;
   logic [31:0] PRDATA, CUR_STATUS, CUR_PC, CUR_SP, CFG_RDATA;
   logic PREADY, PSLVERR, DEBUG_RETURN, DEBUG_ENTRY, IN_DEBUG;
   logic [7:0] THREAD_STOP, FETCH_THREAD;
   logic [4:0] FETCH_REG;
   int err_total = 0, compares = 0, cyc = 0;
   dbu_core u_dut (.CLOCK(CLOCK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .HOST_REQ(HOST_REQ), .CALL_REQ(CALL_REQ),
      .CALL_THREAD(CALL_THREAD), .DEBUG_RETURN(DEBUG_RETURN), .CUR_STATUS(CUR_STATUS),
      .CUR_PC(CUR_PC), .CUR_SP(CUR_SP), .PC_VALID(PC_VALID), .PC(PC),
      .PC_THREAD(PC_THREAD), .MEM_VALID(MEM_VALID), .MEM_LOAD(MEM_LOAD),
      .MEM_ADDR(MEM_ADDR), .MEM_THREAD(MEM_THREAD), .RES_VALID(RES_VALID), .RES_ID(RES_ID),
      .RES_THREAD(RES_THREAD), .CFG_WE(CFG_WE), .CFG_IDX(CFG_IDX), .CFG_WDATA(CFG_WDATA),
      .CFG_RDATA(CFG_RDATA), .DEBUG_ENTRY(DEBUG_ENTRY), .IN_DEBUG(IN_DEBUG),
      .THREAD_STOP(THREAD_STOP), .FETCH_THREAD(FETCH_THREAD), .FETCH_REG(FETCH_REG));
   dbu_core_model u_core (.CLOCK(CLOCK), .RSTN(RSTN), .THR(thr), .RET_DLY(ret_dly),
      .IN_DEBUG(IN_DEBUG), .DEBUG_RETURN(DEBUG_RETURN), .CUR_STATUS(CUR_STATUS),
      .CUR_PC(CUR_PC), .CUR_SP(CUR_SP));
   always #20 CLOCK = ~CLOCK;
   task automatic final_report();
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // hang guard
   always @(posedge CLOCK) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         final_report();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge CLOCK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= {idx, 2'b00};
      PWDATA <= wd;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      do begin
         @(posedge CLOCK);
         n++;
      end while (PREADY !== 1'b1 && n < 20);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      if (n == 20) err_total++;
   endtask
   task automatic wr(input logic [9:0] idx, input logic [31:0] d);
      logic [31:0] v;
      logic e;
      apb(1'b1, idx, d, v, e);
   endtask
   task automatic rdr(input logic [9:0] idx, output logic [31:0] d);
      logic e;
      apb(1'b0, idx, 32'h0, d, e);
   endtask
   // drop triggers, judge entry, then the record after return
   task automatic fire(input logic exp, input logic [31:0] cause, input logic [31:0] data);
      logic [31:0] v;
      int n;
      n = 0;
      @(posedge CLOCK);
      HOST_REQ <= 1'b0;
      CALL_REQ <= 1'b0;
      PC_VALID <= 1'b0;
      MEM_VALID <= 1'b0;
      RES_VALID <= 1'b0;
      #1;
      chk({31'h0, DEBUG_ENTRY}, {31'h0, exp}, "entry");
      if (exp) begin
         while (IN_DEBUG === 1'b1 && n < 40) begin
            @(posedge CLOCK);
            n++;
         end
         chk({31'h0, IN_DEBUG}, 32'h0, "return");
         rdr(IDX_CAUSE, v);
         chk(v, cause, "cause");
         rdr(IDX_DATA, v);
         chk(v, data, "data");
      end
   endtask
   task automatic pc_hit(input logic [31:0] a, input logic [7:0] t, input logic e,
      input logic [31:0] c);
      @(posedge CLOCK);
      PC_VALID <= 1'b1;
      PC <= a;
      PC_THREAD <= t;
      fire(e, c, 32'h0);
   endtask
   task automatic mem(input logic ld, input logic [31:0] a, input logic e,
      input logic [31:0] d);
      @(posedge CLOCK);
      MEM_VALID <= 1'b1;
      MEM_LOAD <= ld;
      MEM_ADDR <= a;
      MEM_THREAD <= 8'h04;
      fire(e, 32'h0001_0404, d);
   endtask
   task automatic t_reset();
      logic [31:0] v;
      logic e;
      rdr(IDX_CAUSE, v);
      chk(v, 32'h0, "cause rst");
      rdr(IDX_IBCTL + 10'h1, v);
      chk(v, 32'h0, "ibctl rst");
      apb(1'b0, 10'h3FF, 32'h0, v, e);
      chk({31'h0, e}, 32'h1, "unmapped");
      $display("t_reset done");
   endtask
   task automatic t_regs();
      logic [9:0] idx [4];
      logic [31:0] msk [4];
      logic [31:0] v;
      idx = '{IDX_SAVED_STATUS, IDX_FTHR, IDX_FREG, IDX_STOP};
      msk = '{32'h0000_06DF, 32'h0000_00FF, 32'h0000_001F, 32'h0000_00FF};
      for (int i = 0; i < 4; i++) begin
         wr(idx[i], 32'hFFFF_FFFF);
         rdr(idx[i], v);
         chk(v, msk[i], "rw mask");
      end
      chk({24'h0, THREAD_STOP}, 32'h0000_00FF, "stop");
      chk({24'h0, FETCH_THREAD}, 32'h0000_00FF, "fthr");
      chk({27'h0, FETCH_REG}, 32'h0000_001F, "freg");
      $display("t_regs done");
   endtask
   task automatic t_entries();
      logic [31:0] v;
      @(posedge CLOCK);
      thr <= 8'h5A;
      HOST_REQ <= 1'b1;
      fire(1'b1, 32'h0000_0001, 32'h0);
      rdr(IDX_SAVED_STATUS, v);
      chk(v, 32'h0000_0785, "status snap");
      rdr(IDX_SAVED_PC, v);
      chk(v, 32'h1000_005A, "pc snap");
      rdr(IDX_SAVED_SP, v);
      chk(v, 32'h2000_005A, "sp snap");
      @(posedge CLOCK);
      ret_dly <= 4'h9;
      CALL_REQ <= 1'b1;
      CALL_THREAD <= 8'h07;
      fire(1'b1, 32'h0000_0702, 32'h0);
      $display("t_entries done");
   endtask
   task automatic t_ibreak();
      wr(IDX_IBADDR + 10'h2, 32'h0000_0400);
      wr(IDX_IBADDR + 10'h3, 32'h0000_0400);
      wr(IDX_IBCTL + 10'h2, 32'h0008_0000);
      pc_hit(32'h0000_0400, 8'h03, 1'b0, 32'h0);
      wr(IDX_IBCTL + 10'h2, 32'h0008_0001);
      wr(IDX_IBCTL + 10'h3, 32'h0008_0001);
      pc_hit(32'h0000_0400, 8'h02, 1'b0, 32'h0);
      pc_hit(32'h0000_0400, 8'h03, 1'b1, 32'h0002_0303);
      wr(IDX_IBCTL + 10'h2, 32'h0);
      wr(IDX_IBCTL + 10'h3, 32'h0);
      wr(IDX_IBADDR + 10'h1, 32'h0000_0400);
      wr(IDX_IBCTL + 10'h1, 32'h0008_0003);
      pc_hit(32'h0000_0404, 8'h03, 1'b1, 32'h0001_0303);
      wr(IDX_IBCTL + 10'h1, 32'h0);
      $display("t_ibreak done");
   endtask
   task automatic t_dwatch();
      wr(IDX_DWADDR1 + 10'h1, 32'h0000_0100);
      wr(IDX_DWADDR2 + 10'h1, 32'h0000_0200);
      wr(IDX_DWCTL + 10'h1, 32'h00FF_0001);
      mem(1'b1, 32'h0000_0180, 1'b0, 32'h0);
      mem(1'b0, 32'h0000_0180, 1'b1, 32'h0000_0180);
      mem(1'b0, 32'h0000_0280, 1'b0, 32'h0);
      wr(IDX_DWCTL + 10'h1, 32'h00FF_0007);
      mem(1'b1, 32'h0000_0280, 1'b1, 32'h0000_0280);
      wr(IDX_DWCTL + 10'h1, 32'h0);
      $display("t_dwatch done");
   endtask
   task automatic t_rwatch_scratch();
      logic [31:0] v;
      wr(IDX_RWMASK, 32'h0000_00FF);
      wr(IDX_RWVAL, 32'h0000_0042);
      wr(IDX_RWCTL, 32'h00FF_0001);
      @(posedge CLOCK);
      RES_VALID <= 1'b1;
      RES_ID <= 32'h0000_1242;
      RES_THREAD <= 8'h06;
      fire(1'b1, 32'h0000_0605, 32'h0000_1242);
      wr(IDX_RWCTL, 32'h00FF_0003);
      @(posedge CLOCK);
      RES_VALID <= 1'b1;
      fire(1'b0, 32'h0, 32'h0);
      @(posedge CLOCK);
      RES_VALID <= 1'b1;
      RES_ID <= 32'h0000_1243;
      fire(1'b1, 32'h0000_0605, 32'h0000_1243);
      @(posedge CLOCK);
      CFG_WE <= 1'b1;
      CFG_IDX <= 3'h3;
      CFG_WDATA <= 32'hCAFE_0003;
      @(posedge CLOCK);
      CFG_WE <= 1'b0;
      rdr(IDX_SCR + 10'h3, v);
      chk(v, 32'hCAFE_0003, "scr cfg");
      wr(IDX_SCR + 10'h5, 32'h5555_AAAA);
      @(posedge CLOCK);
      CFG_IDX <= 3'h5;
      repeat (2) @(posedge CLOCK);
      chk(CFG_RDATA, 32'h5555_AAAA, "scr apb");
      $display("t_rwatch_scratch done");
   endtask
   initial begin
      repeat (3) @(posedge CLOCK);
      RSTN <= 1'b1;
      t_reset();
      t_regs();
      t_entries();
      t_ibreak();
      t_dwatch();
      t_rwatch_scratch();
      final_report();
   end
endmodule
